// [rtl/rxagc_config.sv]
// receive gain-control configuration registers behind an axi4-lite slave
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module rxagc_config
  import rxagc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // settings to the gain-control loop
  output logic agc_enable,
  output rxagc_stage_t stage_enable,
  output rxagc_gain_t gain_setting
);

  // ***********************
  // register state
  // ***********************
  logic idx_msb_reg;
  logic [7:0] main_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [7:0] w_byte_reg;
  logic w_lane_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic agc_enable_reg;
  rxagc_stage_t stage_reg;
  rxagc_gain_t gain_reg;

  // ***********************
  // write channel
  // ***********************
  // address and data are taken in either order; the write lands once both are held
  wire aw_fire = awvalid && awready_reg;
  wire w_fire = wvalid && wready_reg;
  wire aw_have_now = aw_have_reg || aw_fire;
  wire w_have_now = w_have_reg || w_fire;
  wire do_write = aw_have_now && w_have_now && !bvalid_reg;
  wire [ADDR_W-1:0] wr_addr = aw_fire ? awaddr : aw_addr_reg;
  wire [7:0] wr_byte = w_fire ? wdata[7:0] : w_byte_reg;
  wire wr_lane = w_fire ? wstrb[0] : w_lane_reg;
  wire wr_hit_low = (wr_addr == rxagc_addr(IDX_GAIN_LOW));
  wire wr_hit_main = (wr_addr == rxagc_addr(IDX_GAIN_MAIN));
  wire wr_hit_sts = (wr_addr == rxagc_addr(IDX_STATUS));
  wire wr_mapped = wr_hit_low || wr_hit_main || wr_hit_sts;
  wire aw_have_next = aw_have_now && !do_write;
  wire w_have_next = w_have_now && !do_write;
  wire bvalid_next = do_write || (bvalid_reg && !bready);
  // only byte lane 0 carries register bits; upper lanes are reserved
  wire low_write = do_write && wr_hit_low && wr_lane;
  wire main_write = do_write && wr_hit_main && wr_lane;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
    end else begin
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awready_reg <= !aw_have_next && !bvalid_next;
      wready_reg <= !w_have_next && !bvalid_next;
      bvalid_reg <= bvalid_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_reg <= '0;
      w_byte_reg <= '0;
      w_lane_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (aw_fire) aw_addr_reg <= awaddr;
      if (w_fire) begin
        w_byte_reg <= wdata[7:0];
        w_lane_reg <= wstrb[0];
      end
      if (do_write) bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ***********************
  // configuration registers
  // ***********************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idx_msb_reg <= RST_IDX_MSB;
      main_reg <= RST_GAIN_MAIN;
    end else begin
      if (low_write) idx_msb_reg <= wr_byte[LOW_IDX_BIT];
      if (main_write) main_reg <= wr_byte;
    end
  end

  // ***********************
  // decoded settings
  // ***********************
  wire [1:0] stage_sel = main_reg[MAIN_STAGE_LSB +: 2];
  wire [1:0] sat_sel = main_reg[MAIN_SAT_LSB +: 2];
  wire [1:0] step_sel = main_reg[MAIN_STEP_LSB +: 2];
  wire [2:0] first_idx = {idx_msb_reg, main_reg[MAIN_IDX_LSB +: 2]};
  // one continuous driver for the whole settings word, fields in struct order
  wire rxagc_gain_t gain_next = {GAIN_DB_TABLE[first_idx],
    STEP_DB_TABLE[step_sel],
    (step_sel == STEP_RESERVED),
    sat_sel};
  wire rxagc_stage_t stage_next = rxagc_stage_decode(stage_sel);

  // outputs lag a register write by one cycle so that each leaves a flip-flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      agc_enable_reg <= 1'b0;
      stage_reg <= '0;
      gain_reg <= '0;
    end else begin
      agc_enable_reg <= (stage_sel != STAGE_OFF);
      stage_reg <= stage_next;
      gain_reg <= gain_next;
    end
  end

  // ***********************
  // read channel
  // ***********************
  wire ar_fire = arvalid && arready_reg;
  wire rd_hit_low = (araddr == rxagc_addr(IDX_GAIN_LOW));
  wire rd_hit_main = (araddr == rxagc_addr(IDX_GAIN_MAIN));
  wire rd_hit_sts = (araddr == rxagc_addr(IDX_STATUS));
  wire rd_mapped = rd_hit_low || rd_hit_main || rd_hit_sts;
  wire [31:0] low_word = 32'(idx_msb_reg) << LOW_IDX_BIT;
  wire [31:0] main_word = {24'h0, main_reg};
  wire [31:0] sts_word = (32'(gain_reg.first_gain_db) << STS_GAIN_LSB)
    | (32'(gain_reg.step_db) << STS_STEP_LSB)
    | (32'(gain_reg.step_reserved) << STS_STEP_RSV_BIT)
    | (32'(stage_reg) << STS_STAGE_LSB);
  wire [31:0] rd_word = rd_hit_low ? low_word : rd_hit_main ? main_word : rd_hit_sts ? sts_word : 32'h0;
  wire rvalid_next = ar_fire || (rvalid_reg && !rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else begin
      arready_reg <= !rvalid_next;
      rvalid_reg <= rvalid_next;
      if (ar_fire) begin
        rdata_reg <= rd_word;
        rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ***********************
  // outputs
  // ***********************
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign agc_enable = agc_enable_reg;
  assign stage_enable = stage_reg;
  assign gain_setting = gain_reg;

  // ***********************
  // assertions
  // ***********************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ***********************
  // stage decode
  // ***********************
  AST_STAGE_OFF: assert property ((stage_sel == 2'h0) |=> !agc_enable && stage_enable == 3'h0)
    else $error("stage code 00 left gain control active");
  AST_STAGE_SIGNAL: assert property ((stage_sel == 2'h1) |=> agc_enable && stage_enable == 3'h1)
    else $error("stage code 01 did not give signal stage only");
  AST_STAGE_WAIT: assert property ((stage_sel == 2'h2) |=> stage_enable == 3'h5)
    else $error("stage code 10 did not give receive-wait and signal");
  AST_STAGE_ALL: assert property ((stage_sel == 2'h3) |=> stage_enable == 3'h7)
    else $error("stage code 11 did not enable all three stages");
  AST_AGC_WAIT_ON: assert property ((stage_sel == STAGE_WAIT_SIG) |=> agc_enable)
    else $error("stage code 10 left gain control off");
  AST_AGC_ALL_ON: assert property ((stage_sel == STAGE_ALL) |=> agc_enable)
    else $error("stage code 11 left gain control off");

  // ***********************
  // first gain index and table
  // ***********************
  AST_INDEX_SPLIT: assert property (low_write && !wr_byte[0] && main_write == 1'b0
    ##1 (main_reg[3:2] == 2'h0) [*2] |-> gain_setting.first_gain_db == 6'h30)
    else $error("index msb from low register not applied");
  AST_INDEX_MSB_SET: assert property (low_write && wr_byte[LOW_IDX_BIT] |=> first_idx[2])
    else $error("index msb write did not reach the first gain index");
  // every entry is watched so that a swapped pair of codes cannot hide
  AST_GAIN_48DB: assert property ((first_idx == 3'h0) |=> gain_setting.first_gain_db == 6'h30)
    else $error("index 000 did not map to 48 dB");
  AST_GAIN_44DB: assert property ((first_idx == 3'h1) |=> gain_setting.first_gain_db == 6'h2c)
    else $error("index 001 did not map to 44 dB");
  AST_GAIN_40DB: assert property ((first_idx == 3'h2) |=> gain_setting.first_gain_db == 6'h28)
    else $error("index 010 did not map to 40 dB");
  AST_GAIN_36DB: assert property ((first_idx == 3'h3) |=> gain_setting.first_gain_db == 6'h24)
    else $error("index 011 did not map to 36 dB");
  AST_GAIN_32DB: assert property ((first_idx == 3'h4) |=> gain_setting.first_gain_db == 6'h20)
    else $error("index 100 did not map to 32 dB");
  AST_GAIN_TABLE: assert property ((first_idx == 3'h5) |=> gain_setting.first_gain_db == 6'h2a)
    else $error("index 101 did not map to 42 dB");
  AST_GAIN_38DB: assert property ((first_idx == 3'h6) |=> gain_setting.first_gain_db == 6'h26)
    else $error("index 110 did not map to 38 dB");
  AST_GAIN_34DB: assert property ((first_idx == 3'h7) |=> gain_setting.first_gain_db == 6'h22)
    else $error("index 111 did not map to 34 dB");

  // ***********************
  // step and saturation
  // ***********************
  AST_STEP_2DB: assert property ((step_sel == 2'h0) |=> gain_setting.step_db == 3'h2 && !gain_setting.step_reserved)
    else $error("step code 00 did not give 2 dB");
  AST_STEP_4DB: assert property ((step_sel == 2'h1) |=> gain_setting.step_db == 3'h4 && !gain_setting.step_reserved)
    else $error("step code 01 did not give 4 dB");
  AST_STEP: assert property ((step_sel == 2'h2) |=> gain_setting.step_db == 3'h6 && !gain_setting.step_reserved)
    else $error("step code 10 did not give 6 dB");
  AST_STEP_RESERVED: assert property ((step_sel == STEP_RESERVED) |=> gain_setting.step_reserved)
    else $error("step code 11 not flagged reserved");
  AST_SATURATION: assert property ($changed(sat_sel) |=> gain_setting.saturation_count == $past(sat_sel))
    else $error("saturation count not passed to the loop");

  // ***********************
  // reserved bits, unmapped addresses and bus
  // ***********************
  AST_LANE_IGNORED: assert property ((do_write && !wr_lane) |=> $stable(idx_msb_reg) && $stable(main_reg))
    else $error("write with lane 0 strobe low changed a register");
  AST_UNMAPPED_IGNORED: assert property ((do_write && !wr_hit_low && !wr_hit_main)
    |=> $stable(idx_msb_reg) && $stable(main_reg))
    else $error("write to a read-only or unmapped address changed a register");
  AST_MAIN_LANDS: assert property (main_write |=> main_reg == $past(wr_byte))
    else $error("main register write did not land");
  AST_RESERVED_ZERO: assert property (ar_fire && rd_hit_low |=> rvalid && rdata[31:1] == 31'h0)
    else $error("reserved bits of low register read nonzero");
  AST_MAIN_UPPER_ZERO: assert property ((ar_fire && rd_hit_main) |=> rvalid && rdata[31:8] == 24'h0)
    else $error("upper bits of main register read nonzero");
  AST_UNMAPPED_READ: assert property ((ar_fire && !rd_mapped) |=> rvalid && rdata == 32'h0 && rresp == RESP_SLVERR)
    else $error("unmapped read did not return zero with an error response");
  AST_STATUS_GAIN: assert property ((ar_fire && rd_hit_sts) |=> rdata[STS_GAIN_LSB +: 6] == $past(gain_setting.first_gain_db))
    else $error("status word first gain differs from the output");
  AST_STATUS_STEP: assert property ((ar_fire && rd_hit_sts) |=> rdata[STS_STEP_LSB +: 3] == $past(gain_setting.step_db))
    else $error("status word step differs from the output");
  AST_STATUS_STAGE: assert property ((ar_fire && rd_hit_sts) |=> rdata[STS_STAGE_LSB +: 3] == $past(stage_enable))
    else $error("status word stage differs from the output");
  AST_WRITE_RESP: assert property (aw_fire && w_fire |=> bvalid ##0 !awready [*1])
    else $error("write response missing after address and data");
  AST_READ_RESP: assert property (ar_fire |=> rvalid && !arready)
    else $error("read response missing after address");

  COV_MAIN_WRITE: cover property (main_write ##1 bvalid && bready);
  // address ahead of data is legal; a master that offers both at once never reaches this
  COV_SPLIT_WRITE: cover property (aw_fire && !w_fire ##[1:4] w_fire);
  COV_UNMAPPED_READ: cover property (ar_fire && !rd_mapped ##1 rresp == RESP_SLVERR);
  COV_STEP_RESERVED: cover property (gain_setting.step_reserved);
  COV_LANE_IGNORED: cover property (do_write && wr_hit_low && !wr_lane);

endmodule // rxagc_config

// [shared/rxagc_pkg.sv]
// constants, types and lookup functions for the receive gain-control registers
package rxagc_pkg;
  // ***********************
  // bus geometry
  // ***********************
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_GAIN_LOW = 8'h34;
  localparam logic [7:0] IDX_GAIN_MAIN = 8'h35;
  localparam logic [7:0] IDX_STATUS = 8'h36;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ***********************
  // reset values and field positions
  // ***********************
  localparam logic RST_IDX_MSB = 1'h0;
  localparam logic [7:0] RST_GAIN_MAIN = 8'hec;
  localparam int LOW_IDX_BIT = 0;
  localparam int MAIN_STAGE_LSB = 6;
  localparam int MAIN_SAT_LSB = 4;
  localparam int MAIN_IDX_LSB = 2;
  localparam int MAIN_STEP_LSB = 0;
  localparam int STS_GAIN_LSB = 0;
  localparam int STS_STEP_LSB = 8;
  localparam int STS_STEP_RSV_BIT = 12;
  localparam int STS_STAGE_LSB = 16;
  // ***********************
  // codes and tables
  // ***********************
  localparam logic [1:0] STAGE_OFF = 2'h0;
  localparam logic [1:0] STAGE_SIG = 2'h1;
  localparam logic [1:0] STAGE_WAIT_SIG = 2'h2;
  localparam logic [1:0] STAGE_ALL = 2'h3;
  localparam logic [1:0] STEP_RESERVED = 2'h3;
  localparam logic [5:0] GAIN_DB_TABLE [8] = '{6'h30, 6'h2c, 6'h28, 6'h24, 6'h20, 6'h2a, 6'h26, 6'h22};
  localparam logic [2:0] STEP_DB_TABLE [4] = '{3'h2, 3'h4, 3'h6, 3'h0};

  typedef struct packed {
    logic receive_wait_stage;
    logic post_wait_signal;
    logic signal_stage;
  } rxagc_stage_t;

  typedef struct packed {
    logic [5:0] first_gain_db;
    logic [2:0] step_db;
    logic step_reserved;
    logic [1:0] saturation_count;
  } rxagc_gain_t;

  function automatic logic [ADDR_W-1:0] rxagc_addr(input logic [7:0] idx);
    rxagc_addr = {idx, 2'h0};
  endfunction

  function automatic rxagc_stage_t rxagc_stage_decode(input logic [1:0] sel);
    rxagc_stage_t s;
    s.receive_wait_stage = (sel == STAGE_WAIT_SIG) || (sel == STAGE_ALL);
    s.post_wait_signal = (sel == STAGE_ALL);
    s.signal_stage = (sel != STAGE_OFF);
    rxagc_stage_decode = s;
  endfunction
endpackage

// [verification/test_rxagc_config.sv]
// self-checking bench for the receive gain-control configuration registers
`timescale 1ns/10ps
module test_rxagc_config
  import rxagc_pkg::*;
;
  // ***********************
  // clock, reset and bus signals
  // ***********************
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, agc_enable;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  rxagc_stage_t stage_enable;
  rxagc_gain_t gain_setting;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  // expected first gain, step and stage decode, indexed by code
  logic [5:0] gtab [8] = '{6'h30, 6'h2c, 6'h28, 6'h24, 6'h20, 6'h2a, 6'h26, 6'h22};
  logic [2:0] stab [4] = '{3'h2, 3'h4, 3'h6, 3'h0};
  logic [2:0] sttab [4] = '{3'h0, 3'h1, 3'h5, 3'h7};

  rxagc_config dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .agc_enable(agc_enable), .stage_enable(stage_enable),
    .gain_setting(gain_setting));

  always #2.5 aclk = ~aclk;

  // ***********************
  // checking and closing
  // ***********************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // a hung handshake ends here; the whole run needs well under a thousand cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_fail++;
      close_out();
    end
  end

  // ***********************
  // axi4-lite master tasks
  // ***********************
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  // ***********************
  // test sequence
  // ***********************
  initial begin
    logic [1:0] c;
    logic [2:0] idx;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    chk({31'h0, agc_enable}, 32'h1);
    chk({29'h0, stage_enable}, 32'h7);
    chk({20'h0, gain_setting}, {20'h0, 6'h24, 3'h2, 1'h0, 2'h2});
    rd(10'h0d0, 32'h0, RESP_OKAY);
    rd(10'h0d4, 32'hec, RESP_OKAY);
    $display("test reset values done");
    wr(10'h0d0, 32'hffff_fffe, 4'hf, RESP_OKAY);
    rd(10'h0d0, 32'h0, RESP_OKAY);
    wr(10'h0d0, 32'hff, 4'h0, RESP_OKAY);
    rd(10'h0d0, 32'h0, RESP_OKAY);
    wr(10'h0dc, 32'h1, 4'hf, RESP_SLVERR);
    rd(10'h0dc, 32'h0, RESP_SLVERR);
    wr(10'h0d8, 32'hffff_ffff, 4'hf, RESP_OKAY);
    $display("test reserved and unmapped done");
    // every stage, step and saturation code, every gain index
    for (int i = 0; i < 8; i++) begin
      c = 2'(i);
      idx = 3'(i);
      wr(10'h0d0, {31'h0, idx[2]}, 4'h1, RESP_OKAY);
      wr(10'h0d4, {24'h0, c, c, c, c}, 4'h1, RESP_OKAY);
      rd(10'h0d4, {24'h0, c, c, c, c}, RESP_OKAY);
      rd(10'h0d0, {31'h0, idx[2]}, RESP_OKAY);
      rd(10'h0d8, {13'h0, sttab[c], 3'h0, c == 2'h3, 1'h0, stab[c], 2'h0, gtab[idx]}, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk({31'h0, agc_enable}, {31'h0, c != 2'h0});
      chk({29'h0, stage_enable}, {29'h0, sttab[c]});
      chk({20'h0, gain_setting}, {20'h0, gtab[idx], stab[c], c == 2'h3, c});
    end
    $display("test code sweep done");
    // reset again in mid-run: both registers return to their reset values, stage_enable and gain_setting to the settings those decode to
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    chk({29'h0, stage_enable}, 32'h7);
    chk({20'h0, gain_setting}, {20'h0, 6'h24, 3'h2, 1'h0, 2'h2});
    rd(10'h0d0, 32'h0, RESP_OKAY);
    rd(10'h0d4, 32'hec, RESP_OKAY);
    $display("test mid-run reset done");
    close_out();
  end
endmodule // test_rxagc_config
